// >>> rtl/mio_host_end.sv
`timescale 1ns/100ps
`default_nettype none

module mio_host_end #(
  parameter int HALF_DIV = 8,
  parameter int LEN_W    = 16
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // link
  mio_if.host                              link,
  // read request
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire mio_pkg::mio_kind_t          cmd_kind,
  input  wire logic [mio_pkg::ADDR_BITS-1:0] cmd_addr,
  input  wire logic                        cmd_keep,
  input  wire logic [LEN_W-1:0]            cmd_len,
  // read data
  output logic                             rd_valid,
  input  wire logic                        rd_ready,
  output logic [mio_pkg::DATA_W-1:0]       rd_data
);
  import mio_pkg::*;

  // ==========================================================================
  // elaboration check: sync delay must fit inside one half period
  if (HALF_DIV < HALF_MIN_CYC || HALF_DIV <= SYNC_STAGES || HALF_DIV > 255 || LEN_W < 1)
  begin : g_bad_par
    $error("HALF_DIV or LEN_W out of range");
  end

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_SETUP = 4'b0010,
    H_RUN   = 4'b0100,
    H_TAIL  = 4'b1000
  } mio_hstate_t;

  mio_hstate_t       state;
  logic [3:0]        io_meta;
  logic [3:0]        io_s;
  logic [7:0]        dcnt;
  logic              tick;
  logic              stall;
  logic              xip_on;
  logic              exit_frame;
  logic              op_on;
  logic              dual_in;
  logic [1:0]        wl;
  logic [5:0]        k;
  logic [5:0]        pre_end;
  logic [LEN_W-1:0]  nbytes;
  logic [39:0]       tx;
  logic [3:0]        oe;
  logic              rel_pend;
  logic [DATA_W-1:0] rx;
  logic [2:0]        rbit;
  logic              push;
  logic [DATA_W-1:0] next_rx;
  logic              wide_now;
  logic [DATA_W-1:0] buf_mem [0:1];
  logic              wp;
  logic              rp;
  logic [1:0]        fill;

  // ==========================================================================
  // lanes pass two flip-flops before anything reads them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_meta <= 4'h0;
      io_s    <= 4'h0;
    end
    else
    begin
      io_meta <= link.io;
      io_s    <= io_meta;
    end
  end

  assign cmd_ready = (state == H_IDLE) && !(xip_on && cmd_kind != MIO_DUAL_IO);
  assign wide_now  = dual_in && !(op_on && k < 6'(OP_CLKS));
  assign tick      = (state != H_IDLE) && !stall && dcnt == 8'(HALF_DIV - 1);
  // never start a byte that the buffer could not take
  assign stall     = (state == H_RUN) && !link.sck && k >= pre_end && rbit == 3'h0
                     && nbytes != '0 && fill == 2'h2;
  assign push      = tick && link.sck == 1'b0 && state == H_RUN && k >= pre_end
                     && nbytes != '0 && rbit == mio_byte_last(wl);

  // new byte bits arrive MSB first on the top lanes
  always_comb
  begin
    unique case (wl)
      W1:      next_rx = {rx[6:0], io_s[1]};
      W2:      next_rx = {rx[5:0], io_s[1:0]};
      default: next_rx = {rx[3:0], io_s[3:0]};
    endcase
  end

  // ==========================================================================
  // half period divider; holds while stalled so the clock stays low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dcnt <= 8'h00;
    else if (state == H_IDLE || tick)
      dcnt <= 8'h00;
    else if (!stall)
      dcnt <= dcnt + 8'h01;
  end

  // ==========================================================================
  // frame sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= H_IDLE;
      link.cs_n  <= 1'b1;
      link.sck   <= 1'b0;
      xip_on     <= 1'b0;
      exit_frame <= 1'b0;
      op_on      <= 1'b0;
      dual_in    <= 1'b0;
      wl         <= W1;
      k          <= 6'h00;
      pre_end    <= 6'h00;
      nbytes     <= '0;
      tx         <= 40'h0;
      oe         <= 4'h0;
      rel_pend   <= 1'b0;
      rx         <= 8'h00;
      rbit       <= 3'h0;
    end
    else
    begin
      rel_pend <= 1'b0;
      if (rel_pend)
        oe <= 4'h0;
      unique case (state)
        H_IDLE:
        begin
          k    <= 6'h00;
          rbit <= 3'h0;
          if (cmd_valid && xip_on && cmd_kind != MIO_DUAL_IO)
          begin
            // short frame of all ones drops the device out of continuous mode
            exit_frame <= 1'b1;
            op_on      <= 1'b0;
            dual_in    <= 1'b1;
            pre_end    <= 6'(EXIT_CLKS);
            nbytes     <= '0;
            tx         <= '1;
            oe         <= 4'b0011;
            link.cs_n  <= 1'b0;
            state      <= H_SETUP;
          end
          else if (cmd_valid)
          begin
            exit_frame <= 1'b0;
            op_on      <= !xip_on;
            dual_in    <= cmd_kind == MIO_DUAL_IO;
            wl         <= (cmd_kind == MIO_FAST) ? W1 : ((cmd_kind == MIO_QUAD_OUT) ? W4 : W2);
            nbytes     <= cmd_len;
            xip_on     <= cmd_kind == MIO_DUAL_IO && cmd_keep;
            // a continuous frame opens with address bits on both lanes
            oe         <= xip_on ? 4'b0011 : 4'b0001;
            link.cs_n  <= 1'b0;
            state      <= H_SETUP;
            unique case (cmd_kind)
              MIO_FAST:
              begin
                tx      <= {OP_FAST, cmd_addr, DUMMY_BYTE};
                pre_end <= 6'(OP_CLKS + ADDR_CLKS_1 + DUMMY_CLKS);
              end
              MIO_DUAL_OUT:
              begin
                tx      <= {OP_DUAL_OUT, cmd_addr, DUMMY_BYTE};
                pre_end <= 6'(OP_CLKS + ADDR_CLKS_1 + DUMMY_CLKS);
              end
              MIO_QUAD_OUT:
              begin
                tx      <= {OP_QUAD_OUT, cmd_addr, DUMMY_BYTE};
                pre_end <= 6'(OP_CLKS + ADDR_CLKS_1 + DUMMY_CLKS);
              end
              default:
              begin
                tx      <= xip_on ? {cmd_addr, cmd_keep ? MODE_KEEP : MODE_DROP, 8'h00}
                                  : {OP_DUAL_IO, cmd_addr, cmd_keep ? MODE_KEEP : MODE_DROP};
                pre_end <= xip_on ? 6'(ADDR_CLKS_2 + MODE_CLKS)
                                  : 6'(OP_CLKS + ADDR_CLKS_2 + MODE_CLKS);
              end
            endcase
          end
        end
        H_SETUP:
          if (tick)
            state <= H_RUN;
        H_RUN:
          if (tick && !link.sck)
          begin
            // rising edge: device samples now, host samples data lanes
            link.sck <= 1'b1;
            if (k == pre_end - 6'h01)
              rel_pend <= 1'b1;
            if (k >= pre_end && nbytes != '0)
            begin
              rx   <= next_rx;
              rbit <= (rbit == mio_byte_last(wl)) ? 3'h0 : rbit + 3'h1;
              if (rbit == mio_byte_last(wl))
                nbytes <= nbytes - 1'b1;
            end
          end
          else if (tick)
          begin
            // falling edge: next header bits, or end of the frame
            link.sck <= 1'b0;
            if (k < pre_end)
            begin
              k  <= k + 6'h01;
              tx <= wide_now ? {tx[37:0], 2'b00} : {tx[38:0], 1'b0};
              if (op_on && dual_in && k == 6'(OP_CLKS - 1))
                oe <= 4'b0011;
            end
            if ((k + 6'h01 >= pre_end) && nbytes == '0 && rbit == 3'h0)
            begin
              link.cs_n <= 1'b1;
              oe        <= 4'h0;
              state     <= H_TAIL;
            end
          end
        default:
          if (tick)
          begin
            if (exit_frame)
              xip_on <= 1'b0;
            exit_frame <= 1'b0;
            state      <= H_IDLE;
          end
      endcase
    end
  end

  // header bits: lane zero alone, or lane one over lane zero when two wide
  assign link.host_out = wide_now ? {2'b00, tx[39], tx[38]} : {3'b000, tx[39]};
  assign link.host_oe  = oe;

  // ==========================================================================
  // two-entry receive buffer; a full buffer stalls the serial clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp   <= 1'b0;
      rp   <= 1'b0;
      fill <= 2'h0;
    end
    else
    begin
      if (push)
        wp <= ~wp;
      if (rd_valid && rd_ready)
        rp <= ~rp;
      fill <= fill + {1'b0, push} - {1'b0, rd_valid && rd_ready};
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      buf_mem[wp] <= next_rx;
  end

  assign rd_valid = fill != 2'h0;
  assign rd_data  = buf_mem[rp];

endmodule : mio_host_end

`default_nettype wire

// >>> rtl/mio_pkg.sv
package mio_pkg;

  // ==========================================================================
  // sizes and command codes
  localparam int         ADDR_BITS     = 24;
  localparam int         DATA_W        = 8;
  localparam logic [7:0] OP_FAST       = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  localparam logic [3:0] MODE_KEEP_NIB = 4'hA;
  // low nibble left non-zero so that a device which compares it gets caught
  localparam logic [7:0] MODE_KEEP     = 8'hA5;
  localparam logic [7:0] MODE_DROP     = 8'h00;
  localparam logic [7:0] DUMMY_BYTE    = 8'h00;
  localparam int         QE_BIT        = 1;

  // ==========================================================================
  // frame lengths in serial clocks
  localparam int OP_CLKS     = 8;
  localparam int ADDR_CLKS_1 = 24;
  localparam int ADDR_CLKS_2 = 12;
  localparam int MODE_CLKS   = 4;
  localparam int DUMMY_CLKS  = 8;
  localparam int EXIT_CLKS   = 8;

  // ==========================================================================
  // timing: fastest serial clock allowed, as half periods of the 200 MHz clock
  localparam int CLK_MHZ       = 200;
  localparam int SCK_FAST_MHZ  = 104;
  localparam int SCK_MULTI_MHZ = 80;
  localparam int HALF_MIN_CYC  = (CLK_MHZ + 2 * SCK_MULTI_MHZ - 1) / (2 * SCK_MULTI_MHZ);
  localparam int SYNC_STAGES   = 2;

  // ==========================================================================
  // lane width as log2 of lanes used
  localparam logic [1:0] W1 = 2'h0;
  localparam logic [1:0] W2 = 2'h1;
  localparam logic [1:0] W4 = 2'h2;

  typedef enum logic [1:0] {
    MIO_FAST     = 2'h0,
    MIO_DUAL_OUT = 2'h1,
    MIO_QUAD_OUT = 2'h2,
    MIO_DUAL_IO  = 2'h3
  } mio_kind_t;

  // last clock index inside one byte for a given lane width
  function automatic logic [2:0] mio_byte_last(input logic [1:0] wl);
    return 3'((DATA_W >> wl) - 1);
  endfunction : mio_byte_last

endpackage : mio_pkg

// >>> rtl/mio_if.sv
`timescale 1ns/100ps
`default_nettype none

interface mio_if;

  // ==========================================================================
  // link wires; lane two doubles as write_protect_accel_n, lane three as pause
  logic       cs_n;
  logic       sck;
  logic [3:0] host_out;
  logic [3:0] host_oe;
  logic [3:0] dev_out;
  logic [3:0] dev_oe;
  logic [3:0] io;

  // wire level: device wins, then host, else pulled high
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    assign io[i] = dev_oe[i] ? dev_out[i] : (host_oe[i] ? host_out[i] : 1'b1);
  end

  modport dev (input cs_n, input sck, input io, output dev_out, output dev_oe);
  modport host (output cs_n, output sck, output host_out, output host_oe, input io);

endinterface : mio_if

`default_nettype wire

// >>> rtl/mio_dev_end.sv
// Operation
// - all fields MSB first, sampled on rising clock
// - single-lane quick read uses opcode 0Bh
// - host sends opcode, address, dummy byte serially
// - quick read data on lane one, falling edges
// - address increments per byte, wraps to zero
// - chip select high ends read, outputs released
// - reads ignored while program or erase busy; a continuous-mode frame checks on clock one, using last frame's level
// - two-lane data read header on single lane
// - two-lane data read drives lanes zero, one
// - host releases lanes before first data edge
// - four-lane data read drives lanes zero-three
// - four-lane read needs config bit one set
// - two-lane address read: address, mode two-wide
// - mode nibble A keeps continuous mode, skip opcode
// - low mode nibble is ignored
// - other mode nibble leaves continuous mode
// - short frame without valid header leaves continuous mode
// - chip select high ends two-lane address read
`timescale 1ns/100ps
`default_nettype none

module mio_dev_end #(
  parameter int ARRAY_AW = 24
) (
  // link, clocked by the serial clock
  mio_if.dev                                link,
  // system side
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // array load port
  input  wire logic                         ld_we,
  input  wire logic [ARRAY_AW-1:0]          ld_addr,
  input  wire logic [mio_pkg::DATA_W-1:0]   ld_data,
  // status and configuration
  input  wire logic                         prog_busy,
  input  wire logic [7:0]                   config_register,
  output logic                              continuous_mode
);
  import mio_pkg::*;

  // ==========================================================================
  // elaboration check
  if (ARRAY_AW < 1 || ARRAY_AW > ADDR_BITS)
  begin : g_bad_aw
    $error("ARRAY_AW must lie between 1 and the address width");
  end

  typedef enum logic [5:0] {
    D_CMD    = 6'b000001,
    D_ADDR   = 6'b000010,
    D_MODE   = 6'b000100,
    D_DUMMY  = 6'b001000,
    D_DATA   = 6'b010000,
    D_IGNORE = 6'b100000
  } mio_dstate_t;

  logic [DATA_W-1:0]    mem [0:(1<<ARRAY_AW)-1];
  logic                 busy_meta;
  logic                 busy_s;
  logic                 qe_meta;
  logic                 qe_s;
  logic                 execute_in_place;
  logic                 xip_meta;
  logic                 frame_rst;
  mio_dstate_t          state;
  logic [4:0]           cnt;
  logic [6:0]           cmd;
  logic [ADDR_BITS-1:0] addr;
  logic [5:0]           mode_sh;
  logic [1:0]           wl;
  logic                 dual_in;
  logic [DATA_W-1:0]    out_sh;
  logic [2:0]           nbit;
  logic [ADDR_BITS-1:0] ptr;
  logic                 loaded;
  logic [3:0]           oe;
  logic [7:0]           next_op;
  logic [7:0]           next_mode;
  logic [ADDR_BITS-1:0] cur;

  // ==========================================================================
  // array storage, written from the system clock, read at the link
  always_ff @(posedge clk)
  begin
    if (ld_we)
      mem[ld_addr] <= ld_data;
  end

  // ==========================================================================
  // status levels into the serial clock domain; the clock only runs in
  // frames, so a change is seen two serial clocks into a frame at the latest
  always_ff @(posedge link.sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_meta <= 1'b0;
      busy_s    <= 1'b0;
      qe_meta   <= 1'b0;
      qe_s      <= 1'b0;
    end
    else
    begin
      busy_meta <= prog_busy;
      busy_s    <= busy_meta;
      qe_meta   <= config_register[QE_BIT];
      qe_s      <= qe_meta;
    end
  end

  // a frame is over whenever chip select is high, so that level resets it
  assign frame_rst = ~rst_n | link.cs_n;
  assign next_op   = {cmd, link.io[0]};
  assign next_mode = {mode_sh, link.io[1:0]};

  // ==========================================================================
  // continuous mode survives chip select; dropped at each frame start and
  // only rearmed by a fresh mode byte, so any frame cut short leaves it
  always_ff @(posedge link.sck or negedge rst_n)
  begin
    if (!rst_n)
      execute_in_place <= 1'b0;
    else if (state == D_MODE && cnt == 5'(MODE_CLKS - 1))
      execute_in_place <= (next_mode[7:4] == MODE_KEEP_NIB);
    else if (state == D_CMD && cnt == 5'h00)
      execute_in_place <= 1'b0;
  end

  // ==========================================================================
  // header receive on rising serial clock edges
  always_ff @(posedge link.sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      state   <= D_CMD;
      cnt     <= 5'h00;
      cmd     <= 7'h00;
      addr    <= '0;
      mode_sh <= 6'h00;
      wl      <= W1;
      dual_in <= 1'b0;
    end
    else
    begin
      unique case (state)
        D_CMD:
        begin
          if (cnt == 5'h00 && execute_in_place)
          begin
            // opcode omitted: the first clock already carries address bits
            addr    <= {addr[ADDR_BITS-3:0], link.io[1:0]};
            wl      <= W2;
            dual_in <= 1'b1;
            cnt     <= 5'h01;
            state   <= busy_s ? D_IGNORE : D_ADDR;
          end
          else if (cnt == 5'(OP_CLKS - 1))
          begin
            cnt <= 5'h00;
            case (next_op)
              OP_FAST:
              begin
                wl    <= W1;
                state <= busy_s ? D_IGNORE : D_ADDR;
              end
              OP_DUAL_OUT:
              begin
                wl    <= W2;
                state <= busy_s ? D_IGNORE : D_ADDR;
              end
              OP_QUAD_OUT:
              begin
                wl    <= W4;
                state <= (busy_s || !qe_s) ? D_IGNORE : D_ADDR;
              end
              OP_DUAL_IO:
              begin
                wl      <= W2;
                dual_in <= 1'b1;
                state   <= busy_s ? D_IGNORE : D_ADDR;
              end
              default:
                state <= D_IGNORE;
            endcase
          end
          else
          begin
            cmd <= next_op[6:0];
            cnt <= cnt + 5'h01;
          end
        end
        D_ADDR:
        begin
          if (dual_in)
            addr <= {addr[ADDR_BITS-3:0], link.io[1:0]};
          else
            addr <= {addr[ADDR_BITS-2:0], link.io[0]};
          if (cnt == (dual_in ? 5'(ADDR_CLKS_2 - 1) : 5'(ADDR_CLKS_1 - 1)))
          begin
            cnt   <= 5'h00;
            state <= dual_in ? D_MODE : D_DUMMY;
          end
          else
            cnt <= cnt + 5'h01;
        end
        D_MODE:
        begin
          mode_sh <= next_mode[5:0];
          if (cnt == 5'(MODE_CLKS - 1))
            state <= D_DATA;
          else
            cnt <= cnt + 5'h01;
        end
        D_DUMMY:
        begin
          if (cnt == 5'(DUMMY_CLKS - 1))
            state <= D_DATA;
          else
            cnt <= cnt + 5'h01;
        end
        D_DATA, D_IGNORE:
          state <= state;
        default:
          state <= D_IGNORE;
      endcase
    end
  end

  // ==========================================================================
  // data out on falling edges; first falling edge in D_DATA loads the byte
  assign cur = loaded ? ptr : addr;

  always_ff @(negedge link.sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      out_sh <= '0;
      nbit   <= 3'h0;
      ptr    <= '0;
      loaded <= 1'b0;
      oe     <= 4'h0;
    end
    else if (state == D_DATA)
    begin
      if (!loaded || nbit == mio_byte_last(wl))
      begin
        out_sh <= mem[cur[ARRAY_AW-1:0]];
        ptr    <= cur + 24'h000001;
        nbit   <= 3'h0;
        loaded <= 1'b1;
      end
      else
      begin
        out_sh <= out_sh << (4'h1 << wl);
        nbit   <= nbit + 3'h1;
      end
      unique case (wl)
        W1:      oe <= 4'b0010;
        W2:      oe <= 4'b0011;
        default: oe <= 4'b1111;
      endcase
    end
  end

  // lane mapping: single on lane one; dual MSB on lane one; quad MSB on three
  always_comb
  begin
    unique case (wl)
      W1:      link.dev_out = {2'b00, out_sh[7], 1'b0};
      W2:      link.dev_out = {2'b00, out_sh[7:6]};
      default: link.dev_out = out_sh[7:4];
    endcase
  end
  assign link.dev_oe = oe;

  // ==========================================================================
  // continuous mode flag reported on the system clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xip_meta        <= 1'b0;
      continuous_mode <= 1'b0;
    end
    else
    begin
      xip_meta        <= execute_in_place;
      continuous_mode <= xip_meta;
    end
  end

endmodule : mio_dev_end

`default_nettype wire

// >>> verif/mio_link_checker.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// link watcher, sampled on the system clock
module mio_link_checker (
  // system clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // link wires
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_cs_release: assert property (cs_n |-> dev_oe == 4'h0) else $error("drive while deselected");
  a_no_fight: assert property ((dev_oe & host_oe) == 4'h0) else $error("lane contention");
  a_sck_idle: assert property (cs_n |-> !sck) else $error("clock outside frame");
  a_lane_sets: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad lanes");
  // device lanes may only move while the clock is low
  a_hold_high: assert property (sck && $past(sck) && dev_oe != 4'h0 && $past(dev_oe) == dev_oe
    |-> (io & dev_oe) == $past(io & dev_oe)) else $error("data moved on rise");
  a_start_fall: assert property ($rose(dev_oe != 4'h0) |-> !sck) else $error("start on rise");
  a_host_narrow: assert property (host_oe[3:2] == 2'h0) else $error("host on upper lanes");
  a_quiet_start: assert property ($fell(cs_n) |-> dev_oe == 4'h0 [*8]) else $error("early drive");
endmodule : mio_link_checker

`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// bench: host end reads the device end across the link
module tb;
  import mio_pkg::*;
  logic        clk = 0, rst_n = 0, ld_we = 0, prog_busy = 0, cmd_valid = 0, cmd_keep = 0, rd_ready = 0;
  logic [7:0]  ld_addr = 0, ld_data = 0, config_register = 8'h02, rd_data, mem [256];
  logic [23:0] cmd_addr = 0;
  logic [15:0] cmd_len = 0;
  logic [31:0] seed = 32'h2889;
  mio_kind_t   cmd_kind = MIO_FAST;
  logic        cmd_ready, rd_valid, continuous_mode;
  int          fails = 0, samples_checked = 0;

  mio_if lnk ();
  mio_dev_end #(.ARRAY_AW(8)) i_mio_dev_end (.link(lnk), .clk, .rst_n, .ld_we, .ld_addr, .ld_data,
    .prog_busy, .config_register, .continuous_mode);
  mio_host_end i_mio_host_end (.clk, .rst_n, .link(lnk), .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr,
    .cmd_keep, .cmd_len, .rd_valid, .rd_ready, .rd_data);
  mio_link_checker u_chk (.clk, .rst_n, .cs_n(lnk.cs_n), .sck(lnk.sck), .host_oe(lnk.host_oe),
    .dev_oe(lnk.dev_oe), .io(lnk.io));

  always #2.5 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // refused reads see the pulled-up lanes
  function automatic logic [7:0] expb(input logic [23:0] a, input int i, input bit ff);
    return ff ? 8'hFF : mem[8'(a + 24'(i))];
  endfunction : expb

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // one read; the receiver stalls at random, ready drawn afresh each clock, too briefly for the two-entry buffer to fill
  task automatic rd(input mio_kind_t k, input logic [23:0] a, input int n, input bit keep, input bit ff);
    int i;
    logic [31:0] r;
    i = 0;
    @(negedge clk);
    cmd_kind = k;
    {cmd_valid, cmd_addr, cmd_keep, cmd_len} = {1'b1, a, keep, 16'(n)};
    // ready depends on the kind just set, so let it settle before looking
    #1;
    while (cmd_ready !== 1'b1)
    begin
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    cmd_valid = 0;
    while (i < n)
    begin
      @(negedge clk);
      r = xs();
      rd_ready = r[0];
      if (rd_valid === 1'b1 && rd_ready)
      begin
        chk(rd_data, expb(a, i, ff));
        i++;
      end
    end
    while (lnk.cs_n !== 1'b1 || cmd_ready !== 1'b1) @(negedge clk);
    repeat (64) @(negedge clk);
    $display("test done kind=%0d addr=%h", k, a);
  endtask : rd

  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    for (int j = 0; j < 256; j++)
    begin
      @(negedge clk);
      mem[j] = 8'(xs());
      {ld_we, ld_addr, ld_data} = {1'b1, 8'(j), mem[j]};
    end
    @(negedge clk);
    ld_we = 0;
    rd(MIO_FAST, 24'hFFFFFE, 4, 0, 0);
    for (int j = 0; j < 8; j++) rd(mio_kind_t'(j % 4), 24'(xs()), 1 + j, 0, 0);
    rd(MIO_DUAL_IO, 24'h000123, 3, 1, 0);
    chk({7'h0, continuous_mode}, 8'h01);
    rd(MIO_DUAL_IO, 24'hFFFFFF, 3, 1, 0);
    rd(MIO_FAST, 24'h000040, 2, 0, 0);
    chk({7'h0, continuous_mode}, 8'h00);
    rd(MIO_DUAL_IO, 24'h000010, 2, 1, 0);
    rd(MIO_DUAL_IO, 24'h000020, 2, 0, 0);
    chk({7'h0, continuous_mode}, 8'h00);
    config_register = 8'h00;
    rd(MIO_QUAD_OUT, 24'h000050, 2, 0, 1);
    config_register = 8'h02;
    prog_busy = 1;
    rd(MIO_DUAL_OUT, 24'h000060, 2, 0, 1);
    prog_busy = 0;
    rd(MIO_QUAD_OUT, 24'h000070, 2, 0, 0);
    print_verdict();
  end

  // watchdog: about five times the expected run
  initial
  begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule : tb

`default_nettype wire
